// ===== hdl/acr_regs.sv
// codec control register pair behind an axi4-lite slave
// assumes one write and one read at most in flight; single clock, synchronous reset
// What this block does
// - io control word at index 4000
// - bit 15 power-down, resets to one
// - bit 14 bypasses speaker low-pass filter
// - bit 13 bypasses handset low-pass filter
// - bit 12 bypasses input band-pass filter
// - bit 11 enables second speaker driver
// - bit 10 halves analog output full scale
// - bits 6:4 drive input amplifier gain
// - bit 3 enables primary speaker driver
// - bit 2 enables handset driver
// - bits 1:0 choose input source
// - clock word at index 4003, three selectors
// - clock codes: stop, 8k, 16k, test
//
// Added by the designer: the AXI4-Lite slave port.
module acr_regs (
    input  wire logic        mclk_in,
    input  wire logic        rst_in,
    input  wire logic [17:0] s_axi_awaddr_in,
    input  wire logic        s_axi_awvalid_in,
    output logic             s_axi_awready_out,
    input  wire logic [31:0] s_axi_wdata_in,
    input  wire logic [3:0]  s_axi_wstrb_in,
    input  wire logic        s_axi_wvalid_in,
    output logic             s_axi_wready_out,
    output logic [1:0]       s_axi_bresp_out,
    output logic             s_axi_bvalid_out,
    input  wire logic        s_axi_bready_in,
    input  wire logic [17:0] s_axi_araddr_in,
    input  wire logic        s_axi_arvalid_in,
    output logic             s_axi_arready_out,
    output logic [31:0]      s_axi_rdata_out,
    output logic [1:0]       s_axi_rresp_out,
    output logic             s_axi_rvalid_out,
    input  wire logic        s_axi_rready_in,
    output logic             master_power_down_out,
    output logic             speaker_filter_bypass_out,
    output logic             handset_filter_bypass_out,
    output logic             input_filter_bypass_out,
    output logic             second_speaker_enable_out,
    output logic             output_level_limit_out,
    output logic [2:0]       amp_gain_code_out,
    output logic             speaker_driver_enable_out,
    output logic             handset_driver_enable_out,
    output logic [1:0]       input_source_select_out,
    output logic             mic_path_select_out,
    output logic             handset_mic_path_select_out,
    output logic [2:0]       speaker_clock_code_out,
    output logic [2:0]       handset_clock_code_out,
    output logic [2:0]       input_clock_code_out,
    output logic             speaker_clock_valid_out,
    output logic             handset_clock_valid_out,
    output logic             input_clock_valid_out
);
    logic [15:0] aio_q, aio_d;
    logic [15:0] clk_q, clk_d;
    logic        aw_held_q, aw_held_d;
    logic [17:0] aw_addr_q, aw_addr_d;
    logic        w_held_q, w_held_d;
    logic [31:0] w_data_q, w_data_d;
    logic [3:0]  w_strb_q, w_strb_d;
    logic        bvalid_q, bvalid_d;
    logic [1:0]  bresp_q, bresp_d;
    logic        rvalid_q, rvalid_d;
    logic [1:0]  rresp_q, rresp_d;
    logic [31:0] rdata_q, rdata_d;
    logic        wr_go;
    logic        full_word;
    logic [17:0] wr_addr;
    logic [31:0] wr_data;
    logic [3:0]  wr_strb;
    // helper terms for the field assertions: a write with both low byte strobes set landing on each register
    logic        aio_hit;
    logic        clk_hit;

    // registers accept address and data in either order; response waits for both
    assign s_axi_awready_out = !aw_held_q && !bvalid_q;
    assign s_axi_wready_out  = !w_held_q && !bvalid_q;
    assign s_axi_arready_out = !rvalid_q;

    assign wr_addr   = aw_held_q ? aw_addr_q : s_axi_awaddr_in;
    assign wr_data   = w_held_q ? w_data_q : s_axi_wdata_in;
    assign wr_strb   = w_held_q ? w_strb_q : s_axi_wstrb_in;
    assign wr_go     = (aw_held_q || (s_axi_awvalid_in && s_axi_awready_out))
                    && (w_held_q || (s_axi_wvalid_in && s_axi_wready_out));
    // a partial write would tear a 16-bit field group, so it is refused
    assign full_word = &wr_strb[1:0];
    assign aio_hit   = wr_go && full_word && wr_addr == acr_pkg::AIO_ADDR;
    assign clk_hit   = wr_go && full_word && wr_addr == acr_pkg::CLK_ADDR;

    always_comb begin
        aio_d     = aio_q;
        clk_d     = clk_q;
        aw_held_d = aw_held_q;
        aw_addr_d = aw_addr_q;
        w_held_d  = w_held_q;
        w_data_d  = w_data_q;
        w_strb_d  = w_strb_q;
        bvalid_d  = bvalid_q;
        bresp_d   = bresp_q;
        if (s_axi_awvalid_in && s_axi_awready_out) begin
            aw_held_d = 1'b1;
            aw_addr_d = s_axi_awaddr_in;
        end
        if (s_axi_wvalid_in && s_axi_wready_out) begin
            w_held_d = 1'b1;
            w_data_d = s_axi_wdata_in;
            w_strb_d = s_axi_wstrb_in;
        end
        if (wr_go) begin
            aw_held_d = 1'b0;
            w_held_d  = 1'b0;
            bvalid_d  = 1'b1;
            bresp_d   = acr_pkg::RESP_SLVERR;
            if (full_word && wr_addr == acr_pkg::AIO_ADDR) begin
                aio_d   = wr_data[15:0] & acr_pkg::AIO_MASK;
                bresp_d = acr_pkg::RESP_OKAY;
            end else if (full_word && wr_addr == acr_pkg::CLK_ADDR) begin
                clk_d   = wr_data[15:0] & acr_pkg::CLK_MASK;
                bresp_d = acr_pkg::RESP_OKAY;
            end
        end
        if (bvalid_q && s_axi_bready_in) begin
            bvalid_d = 1'b0;
        end
    end

    always_comb begin
        rvalid_d = rvalid_q;
        rresp_d  = rresp_q;
        rdata_d  = rdata_q;
        if (s_axi_arvalid_in && s_axi_arready_out) begin
            rvalid_d = 1'b1;
            rresp_d  = acr_pkg::RESP_OKAY;
            // upper 16 bits and reserved bits always read zero
            if (s_axi_araddr_in == acr_pkg::AIO_ADDR) begin
                rdata_d = {16'h0000, aio_q};
            end else if (s_axi_araddr_in == acr_pkg::CLK_ADDR) begin
                rdata_d = {16'h0000, clk_q};
            end else begin
                rdata_d = 32'h0000_0000;
                rresp_d = acr_pkg::RESP_SLVERR;
            end
        end else if (rvalid_q && s_axi_rready_in) begin
            rvalid_d = 1'b0;
        end
    end

    always_ff @(posedge mclk_in) begin
        if (rst_in) begin
            aio_q     <= acr_pkg::AIO_RESET;
            clk_q     <= acr_pkg::CLK_RESET;
            aw_held_q <= 1'b0;
            aw_addr_q <= 18'h00000;
            w_held_q  <= 1'b0;
            w_data_q  <= 32'h0000_0000;
            w_strb_q  <= 4'h0;
            bvalid_q  <= 1'b0;
            bresp_q   <= 2'h0;
            rvalid_q  <= 1'b0;
            rresp_q   <= 2'h0;
            rdata_q   <= 32'h0000_0000;
        end else begin
            aio_q     <= aio_d;
            clk_q     <= clk_d;
            aw_held_q <= aw_held_d;
            aw_addr_q <= aw_addr_d;
            w_held_q  <= w_held_d;
            w_data_q  <= w_data_d;
            w_strb_q  <= w_strb_d;
            bvalid_q  <= bvalid_d;
            bresp_q   <= bresp_d;
            rvalid_q  <= rvalid_d;
            rresp_q   <= rresp_d;
            rdata_q   <= rdata_d;
        end
    end

    assign s_axi_bvalid_out = bvalid_q;
    assign s_axi_bresp_out  = bresp_q;
    assign s_axi_rvalid_out = rvalid_q;
    assign s_axi_rresp_out  = rresp_q;
    assign s_axi_rdata_out  = rdata_q;

    // field outputs come straight from the stored words
    assign master_power_down_out     = aio_q[acr_pkg::PWR_BIT];
    assign speaker_filter_bypass_out = aio_q[acr_pkg::SPK_BYP_BIT];
    assign handset_filter_bypass_out = aio_q[acr_pkg::HND_BYP_BIT];
    // input path scaling after bypass is the processor's job, not done here
    assign input_filter_bypass_out   = aio_q[acr_pkg::IN_BYP_BIT];
    assign second_speaker_enable_out = aio_q[acr_pkg::SPK2_EN_BIT];
    assign output_level_limit_out    = aio_q[acr_pkg::LIMIT_BIT];
    assign amp_gain_code_out         = aio_q[acr_pkg::GAIN_LSB +: 3];
    assign speaker_driver_enable_out = aio_q[acr_pkg::SPK_EN_BIT];
    assign handset_driver_enable_out = aio_q[acr_pkg::HND_EN_BIT];
    assign input_source_select_out   = aio_q[acr_pkg::SRC_LSB +: 2];
    // the reserved source code selects neither input, same as mute
    assign mic_path_select_out         = aio_q[1:0] == acr_pkg::ACR_SRC_MIC;
    assign handset_mic_path_select_out = aio_q[1:0] == acr_pkg::ACR_SRC_HANDSET;
    assign speaker_clock_code_out    = clk_q[acr_pkg::SPK_CLK_LSB +: 3];
    assign handset_clock_code_out    = clk_q[acr_pkg::HND_CLK_LSB +: 3];
    assign input_clock_code_out      = clk_q[acr_pkg::IN_CLK_LSB +: 3];

    function automatic logic code_ok(input logic [2:0] c);
        code_ok = c == acr_pkg::ACR_CLK_STOP || c == acr_pkg::ACR_CLK_8K
               || c == acr_pkg::ACR_CLK_16K || c == acr_pkg::ACR_CLK_TEST;
    endfunction

    // a reserved code is flagged so the transfer timer can treat it as stopped
    assign speaker_clock_valid_out = code_ok(clk_q[acr_pkg::SPK_CLK_LSB +: 3]);
    assign handset_clock_valid_out = code_ok(clk_q[acr_pkg::HND_CLK_LSB +: 3]);
    assign input_clock_valid_out   = code_ok(clk_q[acr_pkg::IN_CLK_LSB +: 3]);

    chk_power_reset: assert property (@(posedge mclk_in) $past(rst_in) |-> master_power_down_out)
        else $error("power-down not set after reset");
    chk_aio_write: assert property (@(posedge mclk_in) disable iff (rst_in)
        wr_go && full_word && wr_addr == acr_pkg::AIO_ADDR
        |=> aio_q == ($past(wr_data[15:0]) & acr_pkg::AIO_MASK) && bvalid_q)
        else $error("io word write not applied");
    chk_clk_write: assert property (@(posedge mclk_in) disable iff (rst_in)
        wr_go && full_word && wr_addr == acr_pkg::CLK_ADDR
        |=> clk_q == ($past(wr_data[15:0]) & acr_pkg::CLK_MASK))
        else $error("clock word write not applied");
    chk_reserved_zero: assert property (@(posedge mclk_in) disable iff (rst_in)
        (aio_q & ~acr_pkg::AIO_MASK) == 16'h0000 && (clk_q & ~acr_pkg::CLK_MASK) == 16'h0000)
        else $error("reserved bit set");
    chk_partial_ignored: assert property (@(posedge mclk_in) disable iff (rst_in)
        wr_go && !full_word |=> $stable(aio_q) && $stable(clk_q) && bresp_q == acr_pkg::RESP_SLVERR)
        else $error("partial write changed a register");
    chk_read_aio: assert property (@(posedge mclk_in) disable iff (rst_in)
        s_axi_arvalid_in && s_axi_arready_out && s_axi_araddr_in == acr_pkg::AIO_ADDR
        |=> s_axi_rvalid_out && s_axi_rdata_out == {16'h0000, $past(aio_q)})
        else $error("io word read mismatch");
    chk_source_mic: assert property (@(posedge mclk_in) disable iff (rst_in)
        mic_path_select_out |-> input_source_select_out == 2'b10 && !handset_mic_path_select_out)
        else $error("mic path select wrong");
    chk_gain_hold: assert property (@(posedge mclk_in) disable iff (rst_in)
        !wr_go |=> $stable(amp_gain_code_out) && $stable(speaker_driver_enable_out))
        else $error("gain changed without write");
    chk_clock_valid: assert property (@(posedge mclk_in) disable iff (rst_in)
        speaker_clock_code_out == 3'b011 |-> !speaker_clock_valid_out)
        else $error("reserved clock code flagged valid");

    // each field output but power-down must follow the bit written, one cycle after the write lands
    chk_spk_bypass: assert property (@(posedge mclk_in) disable iff (rst_in)
        aio_hit |=> speaker_filter_bypass_out == $past(wr_data[acr_pkg::SPK_BYP_BIT]))
        else $error("speaker bypass not written");
    chk_hnd_bypass: assert property (@(posedge mclk_in) disable iff (rst_in)
        aio_hit |=> handset_filter_bypass_out == $past(wr_data[acr_pkg::HND_BYP_BIT]))
        else $error("handset bypass not written");
    chk_in_bypass: assert property (@(posedge mclk_in) disable iff (rst_in)
        aio_hit |=> input_filter_bypass_out == $past(wr_data[acr_pkg::IN_BYP_BIT]))
        else $error("input bypass not written");
    chk_spk2_enable: assert property (@(posedge mclk_in) disable iff (rst_in)
        aio_hit |=> second_speaker_enable_out == $past(wr_data[acr_pkg::SPK2_EN_BIT]))
        else $error("second speaker enable not written");
    chk_level_limit: assert property (@(posedge mclk_in) disable iff (rst_in)
        aio_hit |=> output_level_limit_out == $past(wr_data[acr_pkg::LIMIT_BIT]))
        else $error("output limit not written");
    chk_gain_write: assert property (@(posedge mclk_in) disable iff (rst_in)
        aio_hit |=> amp_gain_code_out == $past(wr_data[acr_pkg::GAIN_LSB +: 3]))
        else $error("gain code not written");
    chk_spk_enable: assert property (@(posedge mclk_in) disable iff (rst_in)
        aio_hit |=> speaker_driver_enable_out == $past(wr_data[acr_pkg::SPK_EN_BIT]))
        else $error("speaker enable not written");
    chk_hnd_enable: assert property (@(posedge mclk_in) disable iff (rst_in)
        aio_hit |=> handset_driver_enable_out == $past(wr_data[acr_pkg::HND_EN_BIT]))
        else $error("handset enable not written");
    chk_source_write: assert property (@(posedge mclk_in) disable iff (rst_in)
        aio_hit |=> input_source_select_out == $past(wr_data[acr_pkg::SRC_LSB +: 2]))
        else $error("input source not written");
    chk_source_handset: assert property (@(posedge mclk_in) disable iff (rst_in)
        handset_mic_path_select_out |-> input_source_select_out == 2'b01 && !mic_path_select_out)
        else $error("handset path select wrong");
    chk_spk_clock: assert property (@(posedge mclk_in) disable iff (rst_in)
        clk_hit |=> speaker_clock_code_out == $past(wr_data[acr_pkg::SPK_CLK_LSB +: 3]))
        else $error("speaker clock code not written");
    chk_hnd_clock: assert property (@(posedge mclk_in) disable iff (rst_in)
        clk_hit |=> handset_clock_code_out == $past(wr_data[acr_pkg::HND_CLK_LSB +: 3]))
        else $error("handset clock code not written");
    chk_in_clock: assert property (@(posedge mclk_in) disable iff (rst_in)
        clk_hit |=> input_clock_code_out == $past(wr_data[acr_pkg::IN_CLK_LSB +: 3]))
        else $error("input clock code not written");
    chk_hnd_clock_valid: assert property (@(posedge mclk_in) disable iff (rst_in)
        handset_clock_code_out inside {3'b011, 3'b100, 3'b101, 3'b110} |-> !handset_clock_valid_out)
        else $error("reserved handset code flagged valid");
    chk_in_clock_valid: assert property (@(posedge mclk_in) disable iff (rst_in)
        input_clock_code_out inside {3'b000, 3'b001, 3'b010, 3'b111} |-> input_clock_valid_out)
        else $error("legal input code flagged reserved");
    chk_read_clk: assert property (@(posedge mclk_in) disable iff (rst_in)
        s_axi_arvalid_in && s_axi_arready_out && s_axi_araddr_in == acr_pkg::CLK_ADDR
        |=> s_axi_rvalid_out && s_axi_rdata_out == {16'h0000, $past(clk_q)})
        else $error("clock word read mismatch");
    chk_read_unmapped: assert property (@(posedge mclk_in) disable iff (rst_in)
        s_axi_arvalid_in && s_axi_arready_out && s_axi_araddr_in != acr_pkg::AIO_ADDR
        && s_axi_araddr_in != acr_pkg::CLK_ADDR
        |=> s_axi_rresp_out == acr_pkg::RESP_SLVERR && s_axi_rdata_out == 32'h0000_0000)
        else $error("unmapped read not refused");
    // a second write must wait until the answer of the first has been taken
    chk_write_busy: assert property (@(posedge mclk_in) disable iff (rst_in)
        s_axi_bvalid_out |-> !s_axi_awready_out && !s_axi_wready_out)
        else $error("write accepted while answer pending");
    chk_clock_reset: assert property (@(posedge mclk_in) $past(rst_in) |-> clk_q == acr_pkg::CLK_RESET)
        else $error("clock word not cleared by reset");
endmodule

// ===== hdl/acr_pkg.sv
// constants for the codec control register pair
// assumes a 32-bit axi4-lite slave with word registers
package acr_pkg;
    // printed offsets are not all multiples of four: kept as indices, byte address is four times
    localparam logic [15:0] AIO_INDEX      = 16'h4000;
    localparam logic [15:0] CLK_INDEX      = 16'h4003;
    localparam logic [17:0] AIO_ADDR       = {AIO_INDEX, 2'b00};
    localparam logic [17:0] CLK_ADDR       = {CLK_INDEX, 2'b00};
    localparam int          ADDR_W         = 18;
    localparam logic [15:0] AIO_RESET      = 16'h8000;
    localparam logic [15:0] CLK_RESET      = 16'h0000;
    localparam logic [15:0] AIO_MASK       = 16'hfc7f;
    localparam logic [15:0] CLK_MASK       = 16'h01ff;
    localparam int          PWR_BIT        = 15;
    localparam int          SPK_BYP_BIT    = 14;
    localparam int          HND_BYP_BIT    = 13;
    localparam int          IN_BYP_BIT     = 12;
    localparam int          SPK2_EN_BIT    = 11;
    localparam int          LIMIT_BIT      = 10;
    localparam int          GAIN_LSB       = 4;
    localparam int          SPK_EN_BIT     = 3;
    localparam int          HND_EN_BIT     = 2;
    localparam int          SRC_LSB        = 0;
    localparam int          SPK_CLK_LSB    = 6;
    localparam int          HND_CLK_LSB    = 3;
    localparam int          IN_CLK_LSB     = 0;
    localparam logic [1:0]  RESP_OKAY      = 2'h0;
    localparam logic [1:0]  RESP_SLVERR    = 2'h2;

    typedef enum logic [1:0] {
        ACR_SRC_MUTE    = 2'b00,
        ACR_SRC_HANDSET = 2'b01,
        ACR_SRC_MIC     = 2'b10,
        ACR_SRC_RSVD    = 2'b11
    } acr_src_t;

    typedef enum logic [2:0] {
        ACR_CLK_STOP = 3'b000,
        ACR_CLK_8K   = 3'b001,
        ACR_CLK_16K  = 3'b010,
        ACR_CLK_TEST = 3'b111
    } acr_clk_t;
endpackage

// ===== verif/acr_regs_tb.sv
// self-checking bench for the codec control register pair
// assumes acr_regs alone on one 250 mhz clock; the bench is the axi4-lite master
module acr_regs_tb;
    timeunit 1ns;
    timeprecision 1ps;

    logic        mclk_in = 1'b0, rst_in = 1'b1;
    logic [17:0] s_axi_awaddr_in = '0, s_axi_araddr_in = '0;
    logic [31:0] s_axi_wdata_in = '0, s_axi_rdata_out;
    logic [3:0]  s_axi_wstrb_in = '0;
    logic        s_axi_awvalid_in = 1'b0, s_axi_wvalid_in = 1'b0, s_axi_arvalid_in = 1'b0;
    // both response readies stay high: the master is always willing to take an answer
    logic        s_axi_bready_in = 1'b1, s_axi_rready_in = 1'b1;
    logic        s_axi_awready_out, s_axi_wready_out, s_axi_bvalid_out, s_axi_arready_out, s_axi_rvalid_out;
    logic [1:0]  s_axi_bresp_out, s_axi_rresp_out, input_source_select_out;
    logic        master_power_down_out, speaker_filter_bypass_out, handset_filter_bypass_out;
    logic        input_filter_bypass_out, second_speaker_enable_out, output_level_limit_out;
    logic        speaker_driver_enable_out, handset_driver_enable_out, mic_path_select_out;
    logic        handset_mic_path_select_out, speaker_clock_valid_out, handset_clock_valid_out;
    logic        input_clock_valid_out;
    logic [2:0]  amp_gain_code_out, speaker_clock_code_out, handset_clock_code_out, input_clock_code_out;
    logic [15:0] io_view, clk_view, seen_io, seen_clk;
    int          num_errors = 0, checks_done = 0;

    // field outputs packed back into register layout for whole-word compares
    assign io_view  = {master_power_down_out, speaker_filter_bypass_out, handset_filter_bypass_out,
                       input_filter_bypass_out, second_speaker_enable_out, output_level_limit_out, 3'h0,
                       amp_gain_code_out, speaker_driver_enable_out, handset_driver_enable_out,
                       input_source_select_out};
    assign clk_view = {7'h00, speaker_clock_code_out, handset_clock_code_out, input_clock_code_out};

    always #2 mclk_in = ~mclk_in;

    acr_regs dut (
        .mclk_in, .rst_in, .s_axi_awaddr_in, .s_axi_awvalid_in, .s_axi_awready_out, .s_axi_wdata_in,
        .s_axi_wstrb_in, .s_axi_wvalid_in, .s_axi_wready_out, .s_axi_bresp_out, .s_axi_bvalid_out,
        .s_axi_bready_in, .s_axi_araddr_in, .s_axi_arvalid_in, .s_axi_arready_out, .s_axi_rdata_out,
        .s_axi_rresp_out, .s_axi_rvalid_out, .s_axi_rready_in, .master_power_down_out,
        .speaker_filter_bypass_out, .handset_filter_bypass_out, .input_filter_bypass_out,
        .second_speaker_enable_out, .output_level_limit_out, .amp_gain_code_out, .speaker_driver_enable_out,
        .handset_driver_enable_out, .input_source_select_out, .mic_path_select_out,
        .handset_mic_path_select_out, .speaker_clock_code_out, .handset_clock_code_out,
        .input_clock_code_out, .speaker_clock_valid_out, .handset_clock_valid_out, .input_clock_valid_out
    );

    task automatic chk(input logic [39:0] seen, input logic [39:0] exp);
        checks_done++;
        if (seen !== exp) begin
            num_errors++;
            $display("[FAIL] t=%0t seen=%h expected=%h", $time, seen, exp);
        end
    endtask

    task automatic final_report();
        $display("mismatches=%0d comparisons=%0d", num_errors, checks_done);
        if (num_errors == 0 && checks_done > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask

    // ready is sampled mid-cycle: it is set by registered state and holds up to the next edge
    task automatic wr(input logic [17:0] a, input logic [31:0] d, input logic [3:0] s, output logic [1:0] r);
        logic aw_t, w_t, got;
        got = 1'b0;
        @(posedge mclk_in);
        s_axi_awaddr_in  <= a;
        s_axi_wdata_in   <= d;
        s_axi_wstrb_in   <= s;
        s_axi_awvalid_in <= 1'b1;
        s_axi_wvalid_in  <= 1'b1;
        while (!got) begin
            @(negedge mclk_in);
            aw_t     = s_axi_awvalid_in & s_axi_awready_out;
            w_t      = s_axi_wvalid_in & s_axi_wready_out;
            got      = s_axi_bvalid_out;
            r        = s_axi_bresp_out;
            seen_io  = io_view;
            seen_clk = clk_view;
            @(posedge mclk_in);
            if (aw_t) s_axi_awvalid_in <= 1'b0;
            if (w_t) s_axi_wvalid_in <= 1'b0;
        end
    endtask

    task automatic rd(input logic [17:0] a, output logic [1:0] r, output logic [31:0] d);
        logic a_t, got;
        got = 1'b0;
        @(posedge mclk_in);
        s_axi_araddr_in  <= a;
        s_axi_arvalid_in <= 1'b1;
        while (!got) begin
            @(negedge mclk_in);
            a_t = s_axi_arvalid_in & s_axi_arready_out;
            got = s_axi_rvalid_out;
            r   = s_axi_rresp_out;
            d   = s_axi_rdata_out;
            @(posedge mclk_in);
            if (a_t) s_axi_arvalid_in <= 1'b0;
        end
    endtask

    // one write, then both words read back; outputs are judged at the falling edge where the answer is first seen
    task automatic put(input logic [17:0] a, input logic [15:0] d, input logic [3:0] s, input logic [1:0] er,
                       input logic [15:0] ei, input logic [15:0] ec);
        logic [1:0]  r;
        logic [31:0] q;
        wr(a, {16'hffff, d}, s, r);
        chk(40'(r), 40'(er));
        chk(40'({seen_io, seen_clk}), 40'({ei, ec}));
        rd(acr_pkg::AIO_ADDR, r, q);
        chk({6'h0, r, q}, {6'h0, acr_pkg::RESP_OKAY, 16'h0000, ei});
        rd(acr_pkg::CLK_ADDR, r, q);
        chk({6'h0, r, q}, {6'h0, acr_pkg::RESP_OKAY, 16'h0000, ec});
    endtask

    function automatic logic cv(input logic [2:0] c);
        return c inside {3'h0, 3'h1, 3'h2, 3'h7};
    endfunction

    initial begin
        logic [15:0] io_tab [10] = '{16'hffff, 16'h8000, 16'h4000, 16'h2000, 16'h1000,
                                    16'h0800, 16'h0400, 16'h0070, 16'h0008, 16'h0004};
        logic [15:0] ei, ec, v;
        logic [1:0]  r;
        logic [31:0] q;
        ec = 16'h0000;
        repeat (5) @(posedge mclk_in);
        rst_in <= 1'b0;
        chk(40'({io_view, clk_view}), 40'h80000000);
        put(acr_pkg::AIO_ADDR, 16'h0000, 4'h0, acr_pkg::RESP_SLVERR, 16'h8000, 16'h0000);
        foreach (io_tab[k]) begin
            ei = io_tab[k] & 16'hfc7f;
            // bypass bits only flag the path; sample scaling stays with the processing side
            put(acr_pkg::AIO_ADDR, io_tab[k], 4'hf, acr_pkg::RESP_OKAY, ei, ec);
        end
        for (int i = 0; i < 4; i++) begin
            ei = 16'h0350 & 16'hfc7f | 16'(i);
            put(acr_pkg::AIO_ADDR, 16'h0350 | 16'(i), 4'h3, acr_pkg::RESP_OKAY, ei, ec);
            chk(40'({mic_path_select_out, handset_mic_path_select_out}), 40'({i == 2, i == 1}));
        end
        for (int i = 0; i < 8; i++) begin
            v  = {7'h7f, 3'(i), 3'(7 - i), 3'(i ^ 3)};
            ec = v & 16'h01ff;
            put(acr_pkg::CLK_ADDR, v, 4'hf, acr_pkg::RESP_OKAY, ei, ec);
            chk(40'({speaker_clock_valid_out, handset_clock_valid_out, input_clock_valid_out}),
                40'({cv(3'(i)), cv(3'(7 - i)), cv(3'(i ^ 3))}));
        end
        put(acr_pkg::AIO_ADDR, 16'h1234, 4'h1, acr_pkg::RESP_SLVERR, ei, ec);
        put(acr_pkg::CLK_ADDR, 16'h0049, 4'hc, acr_pkg::RESP_SLVERR, ei, ec);
        put({2'b00, acr_pkg::AIO_INDEX}, 16'h0008, 4'hf, acr_pkg::RESP_SLVERR, ei, ec);
        put(acr_pkg::CLK_ADDR - 18'h4, 16'h0008, 4'hf, acr_pkg::RESP_SLVERR, ei, ec);
        rd(acr_pkg::AIO_ADDR + 18'h4, r, q);
        chk({6'h0, r, q}, {6'h0, acr_pkg::RESP_SLVERR, 32'h0});
        rst_in <= 1'b1;
        repeat (2) @(posedge mclk_in);
        rst_in <= 1'b0;
        @(negedge mclk_in);
        chk(40'({io_view, clk_view}), 40'h80000000);
        final_report();
    end

    // the whole sequence needs well under a thousand cycles
    initial begin
        repeat (5000) @(posedge mclk_in);
        num_errors++;
        final_report();
    end
endmodule
